// [common/adc_link_regs.svh]
// constants and timing for the two-wire converter link
// Summary of operation
// - read address launches conversion at R/W fall
// - conversion runs on device's own clock
// - first sample taken at falling edge after R/W
// - device acknowledges matching read address low
// - master releases SDA during address acknowledge
// - first byte: four zeros, upper four bits
// - master acknowledges first data byte low
// - second byte carries six low result bits
// - last two bits are don't care
// - master NAK ends read; device releases SDA
// - master issues STOP after final NAK
// - next sample starts at last lower bit
// - master polls presence with write address
// - write address acknowledged, no conversion, released
// - after poll master sends STOP or restart
// - address: code, select bits, direction bit
// - master ACK after lower byte continues conversions
// - acquisition window lasts 1.12 microseconds
`ifndef ADC_LINK_REGS_SVH
`define ADC_LINK_REGS_SVH

`define REF_CLK_MHZ 50.0
`define ACQ_TIME_US 1.12
`define ACQ_CNT_W 7
`define RESULT_W 10
`define BYTE_BITS 4'h8
`define LAST_DATA_BIT 4'h7
`define DEV_CODE_W 4
`define DEV_SEL_W 3
`define SAR_MSB 10'h200
`define UPPER_PAD 4'h0
`define LOWER_PAD 2'h0
`define SCL_QUARTER 6'h1F
`define LAST_QUARTER 2'h3

`endif

// [common/adc_link_pkg.sv]
// state types shared by both ends of the converter link
package adc_link_pkg;
	typedef enum logic [2:0] {
		B_IDLE = 3'h0,
		B_ADDR = 3'h1,
		B_ADDR_ACK = 3'h3,
		B_SEND = 3'h2,
		B_MACK = 3'h6,
		B_IGNORE = 3'h7
	} bus_state_t;

	typedef enum logic [1:0] {
		C_IDLE = 2'h0,
		C_ACQ = 2'h1,
		C_SAR = 2'h3
	} conv_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_START = 3'h1,
		H_ADDR = 3'h3,
		H_READ = 3'h2,
		H_STOP = 3'h6
	} host_state_t;
endpackage : adc_link_pkg

// [common/adc_link_if.sv]
// two-wire link between the bus master and the converter
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic scl;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda;

	// wired-and with pull-up: any enabled low driver wins
	assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));

	modport device(input scl, input sda, output sda_dev_out, output sda_dev_oe);
	modport host(output scl, output sda_host_out, output sda_host_oe, input sda);
endinterface : adc_link_if
`default_nettype wire

// [src/adc_device.sv]
// converter end: bus slave on the link clock, conversion on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_regs.svh"
module adc_device #(
	// arbitrary device code, not tied to any real part
	parameter logic [`DEV_CODE_W-1:0] DEV_CODE = 4'hA,
	parameter logic [`DEV_SEL_W-1:0] DEV_SELECT = 3'h5
) (
	input wire logic ref_clk,
	input wire logic bus_clk,
	input wire logic rst,
	input wire logic [`RESULT_W-1:0] analog_input,
	adc_link_if.device link,
	output logic conv_busy,
	output logic [`RESULT_W-1:0] last_result
);
	// nearest integer: a ceiling turns the float error of the product into an extra cycle
	localparam int ACQ_CYCLES = int'(`ACQ_TIME_US * `REF_CLK_MHZ);
	localparam logic [`ACQ_CNT_W-1:0] ACQ_LAST = `ACQ_CNT_W'(ACQ_CYCLES - 1);

	// ---------------- link clock domain ----------------
	logic rst_bus_m;
	logic rst_bus;
	logic scl_m;
	logic scl_s;
	logic scl_d;
	logic sda_m;
	logic sda_s;
	logic sda_d;
	logic done_m;
	logic done_s;
	logic done_d;
	logic done_tgl;
	logic [`RESULT_W-1:0] res_word;
	logic conv_tgl;
	logic [`RESULT_W-1:0] res_bus;
	logic [`RESULT_W-1:0] held;
	adc_link_pkg::bus_state_t state;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic rw;
	logic lower;
	logic mack;
	logic sda_oe;

	// reset crosses in as a level, pins as levels
	always_ff @(posedge bus_clk) begin
		rst_bus_m <= rst;
		rst_bus <= rst_bus_m;
		scl_m <= link.scl;
		scl_s <= scl_m;
		scl_d <= scl_s;
		sda_m <= link.sda;
		sda_s <= sda_m;
		sda_d <= sda_s;
		done_m <= done_tgl;
		done_s <= done_m;
		done_d <= done_s;
	end

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
	wire done_evt = done_s ^ done_d;
	wire addr_match = shreg[7:1] == {DEV_CODE, DEV_SELECT};
	wire addr_done = scl_fall & (bitcnt == `BYTE_BITS);
	wire load_upper = (state == adc_link_pkg::B_ADDR_ACK) | lower;
	wire [7:0] upper_byte = {`UPPER_PAD, res_bus[9:6]};
	wire [7:0] lower_byte = {held[5:0], `LOWER_PAD};
	wire [7:0] next_byte = load_upper ? upper_byte : lower_byte;
	wire last_bit = bitcnt == `LAST_DATA_BIT;
	wire launch_first = (state == adc_link_pkg::B_ADDR) & addr_done & addr_match & shreg[0];
	wire launch_next = (state == adc_link_pkg::B_SEND) & scl_fall & last_bit & lower;

	always_ff @(posedge bus_clk) begin
		if (rst_bus) begin
			res_bus <= '0;
		end else if (done_evt) begin
			res_bus <= res_word;
		end
	end

	// conversion request crosses as a toggle
	always_ff @(posedge bus_clk) begin
		if (rst_bus) begin
			conv_tgl <= 1'b0;
		end else if (launch_first | launch_next) begin
			conv_tgl <= ~conv_tgl;
		end
	end

	always_ff @(posedge bus_clk) begin
		if (rst_bus) begin
			state <= adc_link_pkg::B_IDLE;
			bitcnt <= '0;
			shreg <= '0;
			tx <= '0;
			rw <= 1'b0;
			lower <= 1'b0;
			mack <= 1'b0;
			held <= '0;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state <= adc_link_pkg::B_ADDR;
			bitcnt <= '0;
			lower <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_cond) begin
			state <= adc_link_pkg::B_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				adc_link_pkg::B_IDLE, adc_link_pkg::B_IGNORE: begin
				end
				adc_link_pkg::B_ADDR: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end else if (addr_done) begin
						if (addr_match) begin
							sda_oe <= 1'b1;
							rw <= shreg[0];
							state <= adc_link_pkg::B_ADDR_ACK;
						end else begin
							state <= adc_link_pkg::B_IGNORE;
						end
					end
				end
				adc_link_pkg::B_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							held <= res_bus;
							tx <= {next_byte[6:0], 1'b0};
							sda_oe <= ~next_byte[7];
							bitcnt <= '0;
							state <= adc_link_pkg::B_SEND;
						end else begin
							sda_oe <= 1'b0;
							state <= adc_link_pkg::B_IGNORE;
						end
					end
				end
				adc_link_pkg::B_SEND: begin
					if (scl_fall) begin
						if (last_bit) begin
							sda_oe <= 1'b0;
							state <= adc_link_pkg::B_MACK;
						end else begin
							sda_oe <= ~tx[7];
							tx <= {tx[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				adc_link_pkg::B_MACK: begin
					if (scl_rise) begin
						mack <= ~sda_s;
					end else if (scl_fall) begin
						if (mack) begin
							// a new result is only picked up at the start of a pair
							if (lower) begin
								held <= res_bus;
							end
							lower <= ~lower;
							tx <= {next_byte[6:0], 1'b0};
							sda_oe <= ~next_byte[7];
							bitcnt <= '0;
							state <= adc_link_pkg::B_SEND;
						end else begin
							state <= adc_link_pkg::B_IGNORE;
						end
					end
				end
			endcase
		end
	end

	assign link.sda_dev_out = 1'b0;
	assign link.sda_dev_oe = sda_oe;

	// ---------------- converter clock domain ----------------
	logic req_m;
	logic req_s;
	logic req_d;
	logic [`RESULT_W-1:0] ain_m;
	logic [`RESULT_W-1:0] ain_s;
	adc_link_pkg::conv_state_t cstate;
	logic [`ACQ_CNT_W-1:0] cnt;
	logic [`RESULT_W-1:0] hold_v;
	logic [`RESULT_W-1:0] sar;
	logic [`RESULT_W-1:0] mask;

	// analog value is sampled; bits may skew while it moves
	always_ff @(posedge ref_clk) begin
		req_m <= conv_tgl;
		req_s <= req_m;
		req_d <= req_s;
		ain_m <= analog_input;
		ain_s <= ain_m;
	end

	wire conv_go = req_s ^ req_d;
	wire [`RESULT_W-1:0] trial = sar | mask;
	wire keep = trial <= hold_v;
	wire [`RESULT_W-1:0] next_sar = keep ? trial : sar;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cstate <= adc_link_pkg::C_IDLE;
			cnt <= '0;
			hold_v <= '0;
			sar <= '0;
			mask <= '0;
			res_word <= '0;
			done_tgl <= 1'b0;
			conv_busy <= 1'b0;
			last_result <= '0;
		end else if (conv_go) begin
			// a new request restarts sampling even mid-conversion
			cstate <= adc_link_pkg::C_ACQ;
			cnt <= '0;
			hold_v <= ain_s;
			conv_busy <= 1'b1;
		end else begin
			unique case (cstate)
				adc_link_pkg::C_IDLE: begin
				end
				adc_link_pkg::C_ACQ: begin
					hold_v <= ain_s;
					cnt <= cnt + `ACQ_CNT_W'(1);
					if (cnt == ACQ_LAST) begin
						cstate <= adc_link_pkg::C_SAR;
						sar <= '0;
						mask <= `SAR_MSB;
					end
				end
				adc_link_pkg::C_SAR: begin
					sar <= next_sar;
					mask <= mask >> 1;
					if (mask[0]) begin
						res_word <= next_sar;
						last_result <= next_sar;
						done_tgl <= ~done_tgl;
						conv_busy <= 1'b0;
						cstate <= adc_link_pkg::C_IDLE;
					end
				end
			endcase
		end
	end
endmodule : adc_device
`default_nettype wire

// [src/adc_host.sv]
// bus master end: drives SCL from ref_clk and reads conversions
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_regs.svh"
module adc_host (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req,
	input wire logic req_read,
	input wire logic [6:0] req_addr,
	input wire logic [3:0] req_words,
	adc_link_if.host link,
	output logic busy,
	output logic result_valid,
	output logic [`RESULT_W-1:0] result,
	output logic nacked
);
	adc_link_pkg::host_state_t state;
	logic [5:0] div;
	logic [1:0] q;
	logic [3:0] bitn;
	logic [7:0] tx;
	// ninth bit keeps the byte's first bit after the ack slot shifts in
	logic [8:0] rx;
	logic [3:0] upper;
	logic hi;
	logic rd;
	logic [3:0] words;
	logic scl;
	logic sda_oe;
	logic ack_seen;
	logic sda_m;
	logic sda_s;

	always_ff @(posedge ref_clk) begin
		sda_m <= link.sda;
		sda_s <= sda_m;
	end

	wire tick = div == `SCL_QUARTER;
	wire slot_end = tick & (q == `LAST_QUARTER);
	wire ack_slot = bitn == `BYTE_BITS;
	wire more = hi | (words != 4'h1);
	// master's own bit for this slot: address bits, then ack or release
	wire addr_low = ack_slot ? 1'b0 : ~tx[7];
	wire read_low = ack_slot & more;

	always_ff @(posedge ref_clk) begin
		if (rst || state == adc_link_pkg::H_IDLE || tick) begin
			div <= '0;
		end else begin
			div <= div + 6'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= adc_link_pkg::H_IDLE;
			q <= '0;
			bitn <= '0;
			tx <= '0;
			rx <= '0;
			upper <= '0;
			hi <= 1'b0;
			rd <= 1'b0;
			words <= '0;
			scl <= 1'b1;
			sda_oe <= 1'b0;
			ack_seen <= 1'b0;
			busy <= 1'b0;
			result_valid <= 1'b0;
			result <= '0;
			nacked <= 1'b0;
		end else begin
			result_valid <= 1'b0;
			nacked <= 1'b0;
			if (tick) begin
				q <= q + 2'h1;
			end
			unique case (state)
				adc_link_pkg::H_IDLE: begin
					q <= '0;
					if (req) begin
						busy <= 1'b1;
						tx <= {req_addr, req_read};
						rd <= req_read;
						words <= (req_words == 4'h0) ? 4'h1 : req_words;
						state <= adc_link_pkg::H_START;
					end
				end
				adc_link_pkg::H_START: begin
					if (tick) begin
						unique case (q)
							2'h0: scl <= 1'b1;
							2'h1: sda_oe <= 1'b1;
							2'h2: scl <= 1'b0;
							2'h3: begin
								bitn <= '0;
								state <= adc_link_pkg::H_ADDR;
							end
						endcase
					end
				end
				adc_link_pkg::H_ADDR, adc_link_pkg::H_READ: begin
					if (tick) begin
						unique case (q)
							2'h0: sda_oe <= (state == adc_link_pkg::H_ADDR) ? addr_low : read_low;
							2'h1: scl <= 1'b1;
							2'h2: begin
								ack_seen <= ~sda_s;
								rx <= {rx[7:0], sda_s};
							end
							2'h3: scl <= 1'b0;
						endcase
					end
					if (slot_end) begin
						bitn <= ack_slot ? 4'h0 : bitn + 4'h1;
						if (!ack_slot && state == adc_link_pkg::H_ADDR) begin
							tx <= {tx[6:0], 1'b0};
						end
					end
					if (slot_end && ack_slot && state == adc_link_pkg::H_ADDR) begin
						hi <= 1'b1;
						nacked <= ~ack_seen;
						// write address is a presence poll only
						state <= (ack_seen && rd) ? adc_link_pkg::H_READ : adc_link_pkg::H_STOP;
					end
					if (slot_end && state == adc_link_pkg::H_READ) begin
						if (ack_slot) begin
							hi <= ~hi;
							if (hi) begin
								upper <= rx[4:1];
							end else begin
								result <= {upper, rx[8:3]};
								result_valid <= 1'b1;
								words <= words - 4'h1;
								if (words == 4'h1) begin
									state <= adc_link_pkg::H_STOP;
								end
							end
						end
					end
				end
				adc_link_pkg::H_STOP: begin
					if (tick) begin
						unique case (q)
							2'h0: sda_oe <= 1'b1;
							2'h1: scl <= 1'b1;
							2'h2: sda_oe <= 1'b0;
							2'h3: begin
								busy <= 1'b0;
								state <= adc_link_pkg::H_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	assign link.scl = scl;
	assign link.sda_host_out = 1'b0;
	assign link.sda_host_oe = sda_oe;
endmodule : adc_host
`default_nettype wire

// [testbench/adc_two_wire_conversion_read_chk.sv]
// link-level assertions for the two-wire converter interface
`timescale 1ns/1ps
`default_nettype none
module adc_two_wire_conversion_read_chk #(
	parameter logic [6:0] DEV_ADDR = 7'h55
) (
	input wire logic bus_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_host_out,
	input wire logic sda_host_oe,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic nak;
	logic [7:0] bit_n;
	logic [7:0] adr;
	logic [7:0] k;
	logic hi;
	logic start;
	logic match;
	logic data;
	// two samples high, so a fresh bit count never meets a stale level
	assign hi = scl & scl_q;
	assign start = hi & sda_q & ~sda;
	assign match = adr[7:1] == DEV_ADDR;
	assign k = (bit_n - 8'hA) % 8'h12;
	assign data = hi & match & adr[0] & ~nak & (bit_n >= 8'hA);
	always_ff @(posedge bus_clk) begin
		scl_q <= rst | scl;
		sda_q <= rst | sda;
	end
	always_ff @(posedge bus_clk) begin
		if (rst || start) begin
			bit_n <= 8'h0;
			adr <= 8'h0;
			nak <= 1'b0;
		end else begin
			bit_n <= bit_n + {7'h0, scl & ~scl_q};
			if (scl && !scl_q && bit_n < 8'h8) begin
				adr <= {adr[6:0], sda};
			end
			if (data && k == 8'h11 && sda) begin
				nak <= 1'b1;
			end
		end
	end
	default clocking @(posedge bus_clk); endclocking
	default disable iff (rst);
	sequence s_ack_slot;
		hi && bit_n == 8'h9;
	endsequence
	sequence s_addr_done;
		$fell(scl) && bit_n == 8'h8 && match;
	endsequence
	a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_out) else $error("device drove sda high");
	a_host_open_drain: assert property (sda_host_oe |-> !sda_host_out) else $error("host drove sda high");
	a_high_stable: assert property (hi |-> $stable(sda_dev_oe)) else $error("device sda moved while scl high");
	a_addr_quiet: assert property (hi && bit_n inside {[8'h1:8'h8]} |-> !sda_dev_oe)
		else $error("device drove sda during address");
	a_ack_match: assert property (s_ack_slot |-> sda_dev_oe == match && sda == !match)
		else $error("address ack wrong");
	a_ack_in_time: assert property (s_addr_done |-> ##[1:8] sda_dev_oe) else $error("ack late");
	a_host_release: assert property (s_ack_slot |-> !sda_host_oe) else $error("host held sda in ack slot");
	a_upper_zero: assert property (data && k < 8'h4 |-> sda_dev_oe) else $error("upper pad bit not zero");
	a_pad_bits: assert property (data && (k == 8'hF || k == 8'h10) |-> sda_dev_oe)
		else $error("trailing bits not sent as chosen");
	a_mack_release: assert property (data && (k == 8'h8 || k == 8'h11) |-> !sda_dev_oe)
		else $error("device held sda in master ack slot");
	a_nak_release: assert property (nak |-> !sda_dev_oe) else $error("device drove sda after nak");
	a_poll_release: assert property (hi && match && !adr[0] && bit_n >= 8'hA |-> !sda_dev_oe)
		else $error("device drove sda after poll");
	a_miss_quiet: assert property (hi && !match && bit_n >= 8'h9 |-> !sda_dev_oe)
		else $error("device answered other address");
endmodule : adc_two_wire_conversion_read_chk
`default_nettype wire

// [testbench/adc_two_wire_conversion_read_tb.sv]
// self-checking bench: host and converter ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module adc_two_wire_conversion_read_tb;
	localparam logic [6:0] DEV_ADDR = 7'h55;
	logic ref_clk = 1'b0;
	logic bus_clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic req_read = 1'b0;
	logic [6:0] req_addr = 7'h00;
	logic [3:0] req_words = 4'h1;
	logic [9:0] analog_input = 10'h000;
	logic busy;
	logic result_valid;
	logic nacked;
	logic conv_busy;
	logic conv_q = 1'b0;
	logic [9:0] result;
	logic [9:0] last_result;
	logic [31:0] lfsr = 32'h5275;
	logic [9:0] exp_q[$];
	int err_count = 0;
	int checked = 0;
	int nack_seen = 0;
	int conv_seen = 0;
	adc_link_if link();
	always #10 ref_clk = ~ref_clk;
	always #3 bus_clk = ~bus_clk;
	adc_device #(.DEV_CODE(4'hA), .DEV_SELECT(3'h5)) i_adc_device(.ref_clk(ref_clk), .bus_clk(bus_clk), .rst(rst),
		.analog_input(analog_input), .link(link.device), .conv_busy(conv_busy), .last_result(last_result));
	adc_host i_adc_host(.ref_clk(ref_clk), .rst(rst), .req(req), .req_read(req_read), .req_addr(req_addr),
		.req_words(req_words), .link(link.host), .busy(busy), .result_valid(result_valid), .result(result),
		.nacked(nacked));
	adc_two_wire_conversion_read_chk #(.DEV_ADDR(DEV_ADDR)) i_adc_two_wire_conversion_read_chk(.bus_clk(bus_clk),
		.rst(rst), .scl(link.scl), .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
		.sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic check_result(input string what, input logic [9:0] exp, input logic [9:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_result
	task automatic check_count(input string what, input int exp, input int got);
		checked++;
		if (got != exp) begin
			err_count++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_count
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	always @(posedge ref_clk) begin
		conv_q <= conv_busy;
		if (!rst && conv_busy === 1'b1 && conv_q !== 1'b1) conv_seen++;
		if (!rst && nacked === 1'b1) nack_seen++;
		if (!rst && result_valid === 1'b1 && exp_q.size() == 0) check_count("spare result", 0, 1);
		else if (!rst && result_valid === 1'b1) check_result("result", exp_q.pop_front(), result);
	end
	task automatic run(input logic rd, input logic [6:0] addr, input logic [3:0] words, input int nak, input int conv);
		int n0;
		int c0;
		int t;
		n0 = nack_seen;
		c0 = conv_seen;
		t = 0;
		@(posedge ref_clk);
		#1;
		req = 1'b1;
		req_read = rd;
		req_addr = addr;
		req_words = words;
		if (rd && nak == 0) exp_q.push_back(analog_input);
		@(posedge ref_clk);
		#1;
		req = 1'b0;
		// a new level is safe once the running conversion has left acquisition; the bench waits until it has finished
		for (int i = 1; i < words; i++) begin
			@(negedge conv_busy);
			@(posedge ref_clk);
			#1;
			lfsr = lfsr_next(lfsr);
			analog_input = lfsr[9:0];
			exp_q.push_back(analog_input);
		end
		while (busy !== 1'b0 && t < 20000) begin
			@(posedge ref_clk);
			#1;
			t++;
		end
		check_count("nacks", nak, nack_seen - n0);
		check_count("conversions", conv, conv_seen - c0);
		check_count("pending results", 0, exp_q.size());
		check_count("busy timeout", 0, (t >= 20000) ? 1 : 0);
		check_result("last result", analog_input, last_result);
		$display("test done: read %0d addr %h words %0d", rd, addr, words);
	endtask : run
	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 3; i++) begin
			lfsr = lfsr_next(lfsr);
			analog_input = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : lfsr[9:0];
			run(1'b1, DEV_ADDR, 4'h1, 0, 2);
		end
		run(1'b1, DEV_ADDR, 4'h0, 0, 2);
		run(1'b1, DEV_ADDR, 4'h3, 0, 4);
		run(1'b0, DEV_ADDR, 4'h1, 0, 0);
		for (int b = 0; b < 7; b++) run(1'b1, DEV_ADDR ^ (7'h01 << b), 4'h1, 1, 0);
		close_out();
	end
	initial begin
		repeat (80000) @(posedge ref_clk);
		err_count++;
		close_out();
	end
endmodule : adc_two_wire_conversion_read_tb
`default_nettype wire
